/* core/mme_bit_timer.sv */
/*
 bit-time tick generator: one pulse every div clocks, free running, realigned by restart.
 assumes the enclosing block restarts it at each frame edge.
*/
`timescale 1ns/1ps
module mme_bit_timer import mme_pkg::*; #(
    parameter int DIV = BAUD_DIV
) (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic restart, // realign bit timing
    output logic halfTick, // mid bit pulse
    output logic bitTick // end of bit pulse
);
    logic [BAUD_W-1:0] count_r;
    logic [BAUD_W-1:0] count_nxt;

    always_comb begin
        if (restart || count_r == BAUD_W'(DIV - 1)) begin
            count_nxt = '0;
        end else begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign halfTick = !restart && count_r == BAUD_W'(DIV / 2 - 1);
    assign bitTick = !restart && count_r == BAUD_W'(DIV - 1);
endmodule : mme_bit_timer

/* core/mme_entry_control.sv */
/*
 monitor mode entry control: latches the entry mode at power-on reset
 release, derives clock, divider, watchdog and vector page controls,
 and runs the security-byte then break handshake on the serial pin.
 assumes pins are synchronous to clock and reset_n is the power-on reset.
*/
// Functional notes
// (R1) break-state flag clearing needs enable bit
// (R2) erased reset vector permits entry without test voltage
// (R3) host supplies test voltage and clock
// (R4) erased vector, irq high: forced external clock
// (R5) erased vector, irq low: internal clock generator
// (R6) internal generator loads trim unless erased
// (R7) no internal generator option when vector programmed
// (R8) monitor entry only at power-on reset
// (R9) after eight security bytes send break
// (R10) host holds serial pin high after reset
// (R11) bus divide two or four by divider pin
// (R12) divider low bypasses oscillator divide stage
// (R13) watchdog off while test voltage present
// (R14) reset-pin test voltage keeps watchdog off
// (R15) bit rate is bus frequency over 256
// (R16) serial pin driven low only, wired-or
// (R17) nrz format, identical bit rates
// (R18) received break: high two bits, echo break
// (R19) monitor vectors from the fe page
// (R20) pins sampled at release, mode latched
`timescale 1ns/1ps
module mme_entry_control import mme_pkg::*; #(
    parameter int BIT_DIV = BAUD_DIV
) (
    input wire logic clock, // system clock
    input wire logic reset_n, // power-on reset, active low
    input wire mme_straps_s straps, // entry pin levels and vector state
    input wire logic testVoltageRst, // test voltage on reset pin
    input wire logic breakState, // processor in break state
    input wire logic statusClearReq, // peripheral status clear attempt
    input wire logic [7:0] trimByte, // stored clock trim value
    input wire logic serialIn, // serial pin level
    input wire logic [ADDR_W-1:0] regAddr, // register address
    input wire logic [DATA_W-1:0] regWdata, // register write data
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    output logic [DATA_W-1:0] regRdata, // read data, cycle after strobe
    output mme_ctrl_s ctrl, // mode derived controls
    output logic [7:0] trimOut, // trim value to the generator
    output logic statusClearAllow, // flag clear permitted
    output logic serialOut, // serial pin output level (always low)
    output logic serialOe, // serial pin drive enable
    output logic secureBytesDone, // security bytes received and break sent
    output logic [7:0] rxByte // last received byte
);
    typedef enum {S_IDLE, S_START, S_DATA, S_STOP} mme_rx_e;
    typedef enum {T_WAIT, T_GAP, T_BREAK, T_DONE} mme_tx_e;

    mme_mode_e mode_r, mode_nxt;
    logic latched_r, latched_nxt;
    mme_ctrl_s ctrl_r, ctrl_nxt;
    logic [7:0] trim_r, trim_nxt;
    logic break_clear_flag_enable_r, break_clear_flag_enable_nxt;
    logic rstTst_r, rstTst_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic allow_r, allow_nxt;
    mme_rx_e rx_r, rx_nxt;
    logic [3:0] rxBits_r, rxBits_nxt;
    logic [8:0] shift_r, shift_nxt;
    logic [7:0] rxByte_r, rxByte_nxt;
    logic [3:0] secCount_r, secCount_nxt;
    logic breakSeen_r, breakSeen_nxt;
    mme_tx_e tx_r, tx_nxt;
    logic [3:0] txBits_r, txBits_nxt;
    logic oe_r, oe_nxt;
    logic serialPrev_r;
    logic halfTick, bitTick, restart, rxStart;
    logic vectorErased;

    assign vectorErased = straps.vectorHiErased && straps.vectorLoErased;
    assign rxStart = rx_r == S_IDLE && serialPrev_r && !serialIn && tx_r != T_BREAK;
    assign restart = rxStart || (tx_r == T_WAIT && tx_nxt != T_WAIT);

    // (R15) bit rate divider
    mme_bit_timer #(.DIV(BIT_DIV)) u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .restart(restart),
        .halfTick(halfTick),
        .bitTick(bitTick)
    );

    // mode decision at reset release
    always_comb begin
        mode_nxt = mode_r;
        latched_nxt = 1'b1;
        ctrl_nxt = ctrl_r;
        trim_nxt = trim_r;
        rstTst_nxt = rstTst_r || testVoltageRst;
        // (R8) (R20) sample once after power-on release
        if (!latched_r) begin
            if (straps.testVoltageIrq) begin
                // (R11) normal entry divider choice
                mode_nxt = straps.dividerSelect ? MME_NORMAL_DIV4 : MME_NORMAL_DIV2;
            end else if (vectorErased) begin
                // (R2) (R4) (R5) (R7) forced entry only with erased vector
                mode_nxt = straps.irqHigh ? MME_FORCED_EXT : MME_FORCED_ICG;
            end else begin
                mode_nxt = MME_USER;
            end
        end
        ctrl_nxt.monitorMode = mode_nxt != MME_USER;
        // (R5) internal generator select
        ctrl_nxt.useIcg = mode_nxt == MME_FORCED_ICG;
        // (R6) trim load unless erased
        ctrl_nxt.loadTrim = mode_nxt == MME_FORCED_ICG && trimByte != ERASED_BYTE;
        trim_nxt = ctrl_nxt.loadTrim ? trimByte : ERASED_BYTE;
        // (R12) bypass oscillator halving
        ctrl_nxt.bypassOscDiv2 = mode_nxt == MME_NORMAL_DIV2;
        // (R11) bus clock divide
        ctrl_nxt.busDivLog2 = mode_nxt == MME_NORMAL_DIV4 ? 2'd2 : 2'd1;
        // (R13) (R14) watchdog gating
        unique case (mode_nxt)
            MME_NORMAL_DIV2, MME_NORMAL_DIV4: begin
                ctrl_nxt.watchdogOff = straps.testVoltageIrq || rstTst_nxt;
            end
            MME_FORCED_EXT, MME_FORCED_ICG: ctrl_nxt.watchdogOff = 1'b1;
            MME_USER: ctrl_nxt.watchdogOff = 1'b0;
        endcase
        // (R19) vector page
        ctrl_nxt.vectorPage = ctrl_nxt.monitorMode ? MON_VECTOR_PAGE : USER_VECTOR_PAGE;
    end

    // register port and flag-clear gating
    always_comb begin
        break_clear_flag_enable_nxt = break_clear_flag_enable_r;
        rdata_nxt = '0;
        if (regWrite && regAddr == OFS_BREAK_FLAG_CLEAR_CONTROL) begin
            break_clear_flag_enable_nxt = regWdata[BREAK_CLEAR_FLAG_ENABLE_BIT];
        end
        if (regRead) begin
            unique case (regAddr)
                OFS_BREAK_FLAG_CLEAR_CONTROL: rdata_nxt = {break_clear_flag_enable_r, 7'h00};
                OFS_MODE_STATUS: rdata_nxt = {ctrl_r.monitorMode, ctrl_r.useIcg,
                    ctrl_r.bypassOscDiv2, ctrl_r.watchdogOff, secCount_r};
                OFS_BREAK_CTRL: rdata_nxt = rxByte_r;
                default: rdata_nxt = '0;
            endcase
        end
        // (R1) clear allowed only with enable set in break
        allow_nxt = statusClearReq && (!breakState || break_clear_flag_enable_r);
    end

    // serial receiver, nrz 8 data bits
    always_comb begin
        rx_nxt = rx_r;
        rxBits_nxt = rxBits_r;
        shift_nxt = shift_r;
        rxByte_nxt = rxByte_r;
        secCount_nxt = secCount_r;
        breakSeen_nxt = 1'b0;
        // (R17) start bit framing
        unique case (rx_r)
            S_IDLE: begin
                if (rxStart && tx_r != T_GAP) begin
                    rx_nxt = S_START;
                end
            end
            S_START: begin
                if (halfTick) begin
                    rx_nxt = serialIn ? S_IDLE : S_DATA;
                    rxBits_nxt = '0;
                end
            end
            S_DATA: begin
                if (halfTick) begin
                    shift_nxt = {serialIn, shift_r[8:1]};
                    rxBits_nxt = rxBits_r + 4'd1;
                    if (rxBits_r == 4'd8) begin
                        rx_nxt = S_STOP;
                    end
                end
            end
            S_STOP: begin
                rx_nxt = S_IDLE;
                // (R18) all nine bits zero means break
                if (shift_r == 9'h000) begin
                    breakSeen_nxt = 1'b1;
                end else begin
                    rxByte_nxt = shift_r[7:0];
                    // (R9) count security bytes
                    if (ctrl_r.monitorMode && secCount_r != 4'(SECURITY_BYTES)) begin
                        secCount_nxt = secCount_r + 4'd1;
                    end
                end
            end
        endcase
    end

    // break transmitter, drives low only
    always_comb begin
        tx_nxt = tx_r;
        txBits_nxt = txBits_r;
        unique case (tx_r)
            T_WAIT: begin
                // (R9) break after eight bytes
                if (secCount_r == 4'(SECURITY_BYTES) && !secureBytesDone) begin
                    tx_nxt = T_BREAK;
                    txBits_nxt = '0;
                end else if (breakSeen_r) begin
                    // (R18) two idle bits then echo
                    tx_nxt = T_GAP;
                    txBits_nxt = '0;
                end
            end
            T_GAP: begin
                if (bitTick) begin
                    txBits_nxt = txBits_r + 4'd1;
                    if (txBits_r == 4'(ECHO_GAP_BITS - 1)) begin
                        tx_nxt = T_BREAK;
                        txBits_nxt = '0;
                    end
                end
            end
            T_BREAK: begin
                if (bitTick) begin
                    txBits_nxt = txBits_r + 4'd1;
                    if (txBits_r == 4'(BREAK_BITS - 1)) begin
                        tx_nxt = T_DONE;
                    end
                end
            end
            T_DONE: tx_nxt = T_WAIT;
        endcase
        // (R16) pull low only, exactly while breaking
        oe_nxt = tx_nxt == T_BREAK;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= MME_USER;
            latched_r <= 1'b0;
            ctrl_r <= '{1'b0, 1'b0, 1'b0, 1'b0, 2'd1, 1'b0, USER_VECTOR_PAGE};
            trim_r <= ERASED_BYTE;
            rstTst_r <= 1'b0;
            break_clear_flag_enable_r <= BFCC_RESET[BREAK_CLEAR_FLAG_ENABLE_BIT];
            rdata_r <= '0;
            allow_r <= 1'b0;
            rx_r <= S_IDLE;
            rxBits_r <= '0;
            shift_r <= '0;
            rxByte_r <= '0;
            secCount_r <= '0;
            breakSeen_r <= 1'b0;
            tx_r <= T_WAIT;
            txBits_r <= '0;
            oe_r <= 1'b0;
            serialPrev_r <= 1'b1;
            secureBytesDone <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            latched_r <= latched_nxt;
            ctrl_r <= ctrl_nxt;
            trim_r <= trim_nxt;
            rstTst_r <= rstTst_nxt;
            break_clear_flag_enable_r <= break_clear_flag_enable_nxt;
            rdata_r <= rdata_nxt;
            allow_r <= allow_nxt;
            rx_r <= rx_nxt;
            rxBits_r <= rxBits_nxt;
            shift_r <= shift_nxt;
            rxByte_r <= rxByte_nxt;
            secCount_r <= secCount_nxt;
            breakSeen_r <= breakSeen_nxt;
            tx_r <= tx_nxt;
            txBits_r <= txBits_nxt;
            oe_r <= oe_nxt;
            serialPrev_r <= serialIn;
            if (tx_r == T_BREAK && tx_nxt == T_DONE && secCount_r == 4'(SECURITY_BYTES)) begin
                secureBytesDone <= 1'b1;
            end
        end
    end

    assign regRdata = rdata_r;
    assign ctrl = ctrl_r;
    assign trimOut = trim_r;
    assign statusClearAllow = allow_r;
    assign serialOut = 1'b0;
    assign serialOe = oe_r;
    assign rxByte = rxByte_r;

    // a_flag_clear_gate (R1)
    a_flag_clear_gate: assert property (@(posedge clock) disable iff (!reset_n) // (R1)
        statusClearReq && breakState && !break_clear_flag_enable_r |=> !statusClearAllow)
        else $error("flag clear allowed in break without enable");

    // a_mode_held_after (R20)
    a_mode_held_after: assert property (@(posedge clock) disable iff (!reset_n) // (R20)
        latched_r |=> $stable(mode_r))
        else $error("mode changed after latch");

    // a_icg_needs_erased (R7)
    a_icg_needs_erased: assert property (@(posedge clock) disable iff (!reset_n) // (R7)
        !latched_r && !vectorErased && !straps.testVoltageIrq |=> !ctrl_r.useIcg)
        else $error("internal generator chosen with programmed vector");

    // a_forced_wdog_off (R4)
    a_forced_wdog_off: assert property (@(posedge clock) disable iff (!reset_n) // (R4)
        mode_r == MME_FORCED_EXT |-> ctrl_r.watchdogOff && !ctrl_r.useIcg)
        else $error("forced external mode controls wrong");

    // a_bypass_div2 (R12)
    a_bypass_div2: assert property (@(posedge clock) disable iff (!reset_n) // (R12)
        ctrl_r.bypassOscDiv2 |-> ctrl_r.busDivLog2 == 2'd1)
        else $error("bypass without divide by two");

    // a_rst_tst_wdog (R14)
    a_rst_tst_wdog: assert property (@(posedge clock) disable iff (!reset_n) // (R14)
        latched_r && ctrl_r.monitorMode && rstTst_r |=> ctrl_r.watchdogOff)
        else $error("watchdog enabled after reset-pin test voltage");

    // a_vector_page (R19)
    a_vector_page: assert property (@(posedge clock) disable iff (!reset_n) // (R19)
        ctrl_r.vectorPage == (ctrl_r.monitorMode ? MON_VECTOR_PAGE : USER_VECTOR_PAGE))
        else $error("vector page mismatch");

    sequence s_gap_done;
        tx_r == T_GAP ##1 tx_r == T_BREAK;
    endsequence

    // a_break_after_gap (R18)
    a_break_after_gap: assert property (@(posedge clock) disable iff (!reset_n) // (R18)
        s_gap_done |-> serialOe)
        else $error("break not driven after gap");

    // a_no_early_break (R9)
    a_no_early_break: assert property (@(posedge clock) disable iff (!reset_n) // (R9)
        ctrl_r.monitorMode && secCount_r < 4'(SECURITY_BYTES) && !breakSeen_r
        && tx_r == T_WAIT |=> tx_r != T_BREAK)
        else $error("break sent before security bytes");
endmodule : mme_entry_control

/* core/mme_pkg.sv */
/*
 monitor mode entry control: shared constants, types and register map.
 assumes a single 40 MHz clock domain and a plain strobe register port.
*/
package mme_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFS_BREAK_FLAG_CLEAR_CONTROL = 4'h0;
    localparam logic [3:0] OFS_MODE_STATUS = 4'h1;
    localparam logic [3:0] OFS_BREAK_CTRL = 4'h2;
    localparam int BREAK_CLEAR_FLAG_ENABLE_BIT = 7;
    localparam logic [7:0] BFCC_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] MON_VECTOR_PAGE = 8'hfe;
    localparam logic [7:0] USER_VECTOR_PAGE = 8'hff;
    localparam int SECURITY_BYTES = 8;
    localparam int BREAK_BITS = 10;
    localparam int ECHO_GAP_BITS = 2;
    localparam int BAUD_DIV = 256;
    localparam int BAUD_W = 9;
    localparam int CLOCK_MHZ = 40;

    typedef enum {
        MME_USER, MME_NORMAL_DIV2, MME_NORMAL_DIV4, MME_FORCED_EXT, MME_FORCED_ICG
    } mme_mode_e;

    typedef struct packed {
        logic testVoltageIrq;
        logic irqHigh;
        logic vectorHiErased;
        logic vectorLoErased;
        logic dividerSelect;
        logic modeSelect0;
        logic modeSelect1;
    } mme_straps_s;

    typedef struct packed {
        logic monitorMode;
        logic useIcg;
        logic loadTrim;
        logic bypassOscDiv2;
        logic [1:0] busDivLog2;
        logic watchdogOff;
        logic [7:0] vectorPage;
    } mme_ctrl_s;
endpackage : mme_pkg

/* verif/mme_host_model.sv */
/*
 host computer model on the single wired-or serial line.
 assumes the bench resolves the line from both enables with a pullup.
*/
`timescale 1ns/1ps
module mme_host_model #(
    parameter int BIT_DIV = 8
) (
    input wire logic clock, // system clock
    input wire logic lineLevel, // resolved line level
    output logic hostLow // host pulls the line low
);
    initial hostLow = 1'b0;
    // drive low only, one nrz bit
    task automatic send_bit(input logic b);
        @(posedge clock);
        hostLow <= ~b;
        repeat (BIT_DIV - 1) @(posedge clock);
    endtask : send_bit
    // start, data lsb first, stop, then idle gap
    task automatic send_byte(input logic [7:0] b, input int gapBits);
        for (int k = 0; k < 2000 && !lineLevel; k++) @(posedge clock);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++) send_bit(b[i]);
        repeat (2 + gapBits) send_bit(1'b1);
    endtask : send_byte
    task automatic send_break();
        repeat (10) send_bit(1'b0);
        send_bit(1'b1);
    endtask : send_break
endmodule : mme_host_model

/* verif/monitor_mode_entry_control_bench.sv */
/*
 self-checking bench for the monitor mode entry control.
 assumes a 40 MHz clock and a shortened bit time of 8 clocks.
*/
`timescale 1ns/1ps
module monitor_mode_entry_control_bench import mme_pkg::*;;
    localparam int BIT = 8;
    typedef struct packed {
        logic [6:0] s;
        logic [7:0] trim;
        logic mon, internal_clock_generator, byp, wd;
        logic [1:0] div;
        logic [7:0] page, trimO;
    } mme_row_s;
    logic clock = 1'b0, reset_n = 1'b0, testVoltageRst = 1'b0;
    logic breakState = 1'b0, statusClearReq = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    mme_straps_s straps = '0;
    logic [7:0] trimByte = 8'h5a, regWdata = 8'h00, regRdata, trimOut, rxByte, rd;
    logic [3:0] regAddr = 4'h0;
    mme_ctrl_s ctrl;
    logic statusClearAllow, serialOut, serialOe, secureBytesDone, hostLow, lineLevel;
    int n_errors = 0, check_count = 0, cyc = 0, relCyc = 0, n, gap;
    mme_row_s r;
    // first two rows stand for the host's test voltage on irq
    mme_row_s rows [9] = '{
        '{7'h62, 8'h5a, 1'b1, 1'b0, 1'b1, 1'b1, 2'h1, 8'hfe, 8'hff},
        '{7'h66, 8'h5a, 1'b1, 1'b0, 1'b0, 1'b1, 2'h2, 8'hfe, 8'hff},
        '{7'h38, 8'h5a, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 8'hfe, 8'hff},
        '{7'h3c, 8'h5a, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 8'hfe, 8'hff},
        '{7'h18, 8'h5a, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 8'hfe, 8'h5a},
        '{7'h18, 8'hff, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 8'hfe, 8'hff},
        '{7'h20, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 8'hff, 8'hff},
        '{7'h00, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 8'hff, 8'hff},
        '{7'h10, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 8'hff, 8'hff}
    };
    assign lineLevel = ~(serialOe & ~serialOut) & ~hostLow;
    mme_entry_control #(.BIT_DIV(BIT)) i_mme_entry_control (
        .clock(clock), .reset_n(reset_n), .straps(straps), .testVoltageRst(testVoltageRst),
        .breakState(breakState), .statusClearReq(statusClearReq), .trimByte(trimByte),
        .serialIn(lineLevel), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .ctrl(ctrl), .trimOut(trimOut),
        .statusClearAllow(statusClearAllow), .serialOut(serialOut), .serialOe(serialOe),
        .secureBytesDone(secureBytesDone), .rxByte(rxByte)
    );
    mme_host_model #(.BIT_DIV(BIT)) i_mme_host_model (
        .clock(clock), .lineLevel(lineLevel), .hostLow(hostLow)
    );
    initial begin
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (hostLow) relCyc <= cyc + 1;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check8
    task automatic check1(input string nm, input logic e, input logic g);
        check8(nm, {7'h0, e}, {7'h0, g});
    endtask : check1
    task automatic checkn(input string nm, input int e, input int g);
        check_count++;
        if (g != e) begin
            n_errors++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask : checkn
    task automatic do_reset(input logic [6:0] s);
        @(posedge clock);
        reset_n <= 1'b0;
        straps <= mme_straps_s'(s);
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask : do_reset
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : reg_read
    task automatic measure_low(output int cnt, output int g);
        cnt = 0;
        g = -1;
        for (int k = 0; k < 60 * BIT && serialOe !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        if (serialOe === 1'b1) g = cyc - relCyc;
        while (serialOe === 1'b1 && cnt < 300) begin
            cnt++;
            @(posedge clock);
            #1;
        end
    endtask : measure_low
    task automatic wait_clk(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : wait_clk
    initial begin
        wait_clk(90000);
        n_errors++;
        stop_test();
    end
    initial begin
        do_reset(7'h00);
        foreach (rows[i]) begin
            r = rows[i];
            trimByte <= r.trim;
            do_reset(r.s);
            repeat (2) begin
                check1("monitor", r.mon, ctrl.monitorMode);
                check1("icg", r.internal_clock_generator, ctrl.useIcg);
                check1("bypass", r.byp, ctrl.bypassOscDiv2);
                check1("wdog", r.wd, ctrl.watchdogOff);
                check8("page", r.page, ctrl.vectorPage);
                check8("trim", r.trimO, trimOut);
                if (r.s[6]) check8("busdiv", {6'h0, r.div}, {6'h0, ctrl.busDivLog2});
                straps <= mme_straps_s'(r.s ^ 7'h3f);
                wait_clk(3);
            end
        end
        do_reset(7'h38);
        wait_clk(30);
        for (int i = 0; i < 7; i++) i_mme_host_model.send_byte(8'(8'h30 + i), i % 2);
        check1("early done", 1'b0, secureBytesDone);
        check1("early break", 1'b0, serialOe);
        fork
            i_mme_host_model.send_byte(8'ha5, 0);
            measure_low(n, gap);
        join
        checkn("break len", 10 * BIT, n);
        check1("sec done", 1'b1, secureBytesDone);
        check8("rx byte", 8'ha5, rxByte);
        reg_read(4'h2, rd);
        check8("rx reg", 8'ha5, rd);
        reg_read(4'h1, rd);
        check8("status", 8'h98, rd);
        fork
            i_mme_host_model.send_break();
            measure_low(n, gap);
        join
        checkn("echo len", 10 * BIT, n);
        check1("echo gap", 1'b1, gap >= BIT && gap <= 3 * BIT);
        reg_read(4'h0, rd);
        check8("bfcc reset", 8'h00, rd);
        breakState <= 1'b1;
        statusClearReq <= 1'b1;
        wait_clk(2);
        check1("clear blocked", 1'b0, statusClearAllow);
        breakState <= 1'b0;
        wait_clk(2);
        check1("clear normal", 1'b1, statusClearAllow);
        reg_write(4'h0, 8'h80);
        breakState <= 1'b1;
        wait_clk(2);
        check1("clear enabled", 1'b1, statusClearAllow);
        reg_write(4'hf, 8'hff);
        reg_read(4'hf, rd);
        check8("unmapped", 8'h00, rd);
        reg_read(4'h0, rd);
        check8("bfcc", 8'h80, rd);
        reg_write(4'h0, 8'h7f);
        reg_read(4'h0, rd);
        check8("bfcc clr", 8'h00, rd);
        do_reset(7'h20);
        wait_clk(30);
        for (int i = 0; i < 8; i++) i_mme_host_model.send_byte(8'h41 + i, 0);
        measure_low(n, gap);
        checkn("user break", 0, n);
        do_reset(7'h62);
        straps <= mme_straps_s'(7'h22);
        wait_clk(3);
        check1("wdog tv gone", 1'b0, ctrl.watchdogOff);
        do_reset(7'h62);
        testVoltageRst <= 1'b1;
        wait_clk(2);
        straps <= mme_straps_s'(7'h22);
        wait_clk(4);
        check1("wdog rst tv", 1'b1, ctrl.watchdogOff);
        check1("still mon", 1'b1, ctrl.monitorMode);
        stop_test();
    end
endmodule : monitor_mode_entry_control_bench
